// ### design/isc_pkg.sv
// Shared constants, opcodes, states and carrier types of the instruction sequencer
package isc_pkg;

    // Widths and field positions
    localparam int WORD_W  = 24;
    localparam int ADDR_W  = 16;
    localparam int Y_W     = 15;
    localparam int IDX_W   = 18;
    localparam int IDX_N   = 3;
    localparam int MASK_W  = 8;
    localparam int UNIT_W  = 3;
    localparam int CYC_W   = 6;
    localparam int IO_CH   = 4;
    localparam int IO_CH_W = 2;
    localparam int F_HI    = 23;
    localparam int F_LO    = 18;
    localparam int IND_BIT = 17;
    localparam int IDX_HI  = 16;
    localparam int IDX_LO  = 15;
    localparam int ROT_BITS = 8;

    // Status word layout
    localparam int ST_UNIT_LO = 8;
    localparam int ST_LOCK    = 11;
    localparam int STAT_W     = 12;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MEM_CYCLE_NS  = 750;
    localparam int MOD_EXT_NS    = 100;
    localparam int SHIFT_STEP_NS = 100;
    localparam int MEM_CYCLES    = MEM_CYCLE_NS / CLK_PERIOD_NS;
    localparam int MOD_EXT_CYC   = (MOD_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHIFT_CYC     = (SHIFT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CYC_W-1:0] CYC_HALF    = CYC_W'(MEM_CYCLES / 2);
    localparam logic [CYC_W-1:0] CYC_END     = CYC_W'(MEM_CYCLES - 1);
    localparam logic [CYC_W-1:0] CYC_END_EXT = CYC_W'(MEM_CYCLES - 1 + MOD_EXT_CYC);
    localparam logic [CYC_W-1:0] STEP_END    = CYC_W'(SHIFT_CYC - 1);

    // Reset values and fixed addresses
    localparam logic [ADDR_W-1:0] RESET_PC    = 16'h0100;
    localparam logic [ADDR_W-1:0] IO_BCW_BASE = 16'h0040;
    localparam logic [Y_W-1:0]    Y_PC        = 15'h0000;
    localparam logic [Y_W-1:0]    Y_ACC       = 15'h0001;
    localparam logic [WORD_W-1:0] WORD_ONE    = 24'h000001;

    // Function codes
    localparam logic [5:0] OP_STOP    = 6'h00;
    localparam logic [5:0] OP_STSTAT  = 6'h01;
    localparam logic [5:0] OP_LDSTAT  = 6'h02;
    localparam logic [5:0] OP_JUMP    = 6'h07;
    localparam logic [5:0] OP_LOCK    = 6'h08;
    localparam logic [5:0] OP_ADD     = 6'h09;
    localparam logic [5:0] OP_SUB     = 6'h0A;
    localparam logic [5:0] OP_AND     = 6'h0B;
    localparam logic [5:0] OP_XOR     = 6'h0C;
    localparam logic [5:0] OP_LDB     = 6'h0E;
    localparam logic [5:0] OP_LDA     = 6'h0F;
    localparam logic [5:0] OP_STA     = 6'h13;
    localparam logic [5:0] OP_INCR    = 6'h17;
    localparam logic [5:0] OP_LDCON   = 6'h18;
    localparam logic [5:0] OP_IDXSKIP = 6'h19;
    localparam logic [5:0] OP_STADR   = 6'h1A;
    localparam logic [5:0] OP_CSHIFT  = 6'h1B;
    localparam logic [5:0] OP_SHR     = 6'h1C;
    localparam logic [5:0] OP_SHL     = 6'h1D;
    localparam logic [5:0] OP_ESCAPE  = 6'h1F;
    localparam logic [5:0] OP_MPROT   = 6'h24;

    // Word modifier modes
    localparam logic [1:0] MOD_INC  = 2'h0;
    localparam logic [1:0] MOD_DEC  = 2'h1;
    localparam logic [1:0] MOD_ROT8 = 2'h2;
    localparam logic [1:0] MOD_PASS = 2'h3;

    typedef enum logic [2:0] {
        ST_HALT  = 3'b000,
        ST_FETCH = 3'b001,
        ST_IND   = 3'b010,
        ST_OPER  = 3'b011,
        ST_SHIFT = 3'b100,
        ST_IO    = 3'b101
    } isc_state_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } isc_mreq_t;

endpackage

// ### design/isc_incdec.sv
// Memory word incrementer, decrementer and character rotator
`timescale 1ns/1ps
module isc_incdec
    import isc_pkg::*;
(
    // Word path
    input  wire logic [WORD_W-1:0] wordIn,
    input  wire logic [1:0]        mode,
    output logic      [WORD_W-1:0] wordOut
);

    wire [WORD_W-1:0] incW = wordIn + WORD_ONE;
    wire [WORD_W-1:0] decW = wordIn - WORD_ONE;
    wire [WORD_W-1:0] rotW = {wordIn[WORD_W-ROT_BITS-1:0], wordIn[WORD_W-1 -: ROT_BITS]};

    // Modification between read and restore
    assign wordOut = (mode == MOD_INC)  ? incW : // RULE6
                     (mode == MOD_DEC)  ? decW :
                     (mode == MOD_ROT8) ? rotW : // RULE20
                     wordIn;

endmodule // isc_incdec

// ### design/isc_core.sv
// Instruction fetch, indirect and operand sequencing core with protect and I/O priority
//
// Operation
// RULE1 - Three 18-bit index registers; selected one added to operand address.
// RULE2 - Operand writes: masked upper address bits must match the instruction's page.
// RULE3 - Protect violation blocks the operand write and pulses the protect interrupt.
// RULE4 - Parallel 24-bit two's complement adder result goes to accumulator.
// RULE5 - Priority network records every I/O request and serves them in order.
// RULE6 - Incrementer/decrementer modifies a word between read and restore.
// RULE7 - Execution is a series of sequences, each one memory read/restore cycle.
// RULE8 - Fetch increments the program counter, reads and restores the instruction.
// RULE9 - Decode at fetch midpoint; simple direct instructions finish in fetch.
// RULE10 - Indexing happens inside the fetch sequence, no extra sequence.
// RULE11 - Indirect flag runs an indirect sequence giving the effective address.
// RULE12 - Indirect words with indirect bit set repeat indexing and indirection.
// RULE13 - Operand sequence reads or writes; address 1 uses accumulator, no sequence.
// RULE14 - Modifying operand cycles are lengthened by 100 ns.
// RULE15 - Word fields: function 23..18, indirect 17, index 16..15, address 14..0.
// RULE16 - Each indirect sequence costs one memory cycle.
// RULE17 - Indexing costs no time.
// RULE18 - Shifts are open-ended, one memory cycle plus 100 ns per position.
// RULE19 - Index skip decrements operand, restores it, skips next if negative.
// RULE20 - Character shift rotates operand left by 8 bits and restores it.
// RULE21 - Unit select persists until another unit select.
// RULE22 - Store and load status save and restore all designators.
// RULE23 - Operand address 1 selects accumulator, 0 selects program counter.
// RULE24 - Unassigned function codes act as no-operations after fetch.
`timescale 1ns/1ps
module isc_core
    import isc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Operator run switch
    input  wire logic                runPin,
    // Core memory
    output isc_mreq_t                memReq,
    input  wire logic [WORD_W-1:0]   memRdData,
    // I/O channels
    input  wire logic [IO_CH-1:0]    ioReqPin,
    output logic                     ioGrant,
    output logic [IO_CH_W-1:0]       ioChan,
    output logic                     ioDone,
    // Status
    output logic                     halted,
    output logic                     protectIrq,
    output logic [WORD_W-1:0]        accOut,
    output logic [ADDR_W-1:0]        pcOut,
    output logic [UNIT_W-1:0]        unitSel
);

    isc_state_t        st_r;
    logic [CYC_W-1:0]  cyc_r;
    logic [ADDR_W-1:0] pc_r;
    logic [ADDR_W-1:0] instrPc_r;
    logic [WORD_W-1:0] acc_r;
    logic [WORD_W-1:0] instr_r;
    logic [WORD_W-1:0] opnd_r;
    logic [Y_W-1:0]    ea_r;
    logic [Y_W-1:0]    shCnt_r;
    logic              indFlag_r;
    logic [IDX_W-1:0]  idx_r [IDX_N];
    logic [MASK_W-1:0] mask_r;
    logic [UNIT_W-1:0] unit_r;
    logic              lock_r;
    logic [IO_CH-1:0]  pend_r;
    logic [IO_CH_W-1:0] chan_r;
    logic              grant_r;
    logic              done_r;
    logic              irq_r;
    logic              halt_r;
    isc_mreq_t         mreq_r;
    logic [2:0]        runSync_r;
    logic [IO_CH-1:0]  ioS1_r;
    logic [IO_CH-1:0]  ioS2_r;
    logic [IO_CH-1:0]  ioS3_r;
    logic [WORD_W-1:0] modOut;

    function automatic logic protViol(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b,
                                      input logic [MASK_W-1:0] m);
        protViol = |(m & (a[ADDR_W-1 -: MASK_W] ^ b[ADDR_W-1 -: MASK_W]));
    endfunction

    // Field decode
    wire [5:0]        fcode  = instr_r[F_HI:F_LO]; // RULE15
    wire [1:0]        curB   = instr_r[IDX_HI:IDX_LO];
    wire [1:0]        rdB    = memRdData[IDX_HI:IDX_LO];
    wire [Y_W-1:0]    rdY    = memRdData[Y_W-1:0];
    wire [IDX_W-1:0]  rdIdx  = (rdB == 2'h0) ? '0 : idx_r[rdB - 2'h1];
    wire [Y_W-1:0]    rdEa   = rdY + rdIdx[Y_W-1:0]; // RULE1
    wire [ADDR_W-1:0] opAddr = {1'b0, ea_r};

    // Instruction classes
    wire isMod  = (fcode == OP_INCR) || (fcode == OP_IDXSKIP) || (fcode == OP_CSHIFT);
    wire wrOp   = isMod || (fcode == OP_STA) || (fcode == OP_STADR) || (fcode == OP_STSTAT);
    wire rdOp   = (fcode == OP_ADD) || (fcode == OP_SUB) || (fcode == OP_AND)
               || (fcode == OP_XOR) || (fcode == OP_LDA) || (fcode == OP_LDB)
               || (fcode == OP_LDSTAT);
    wire needOp = wrOp || rdOp;
    wire isShift = (fcode == OP_SHR) || (fcode == OP_SHL);
    wire regOp  = (ea_r == Y_ACC) || (ea_r == Y_PC); // RULE23

    // Sequence timing
    wire              memSeq = (st_r == ST_FETCH) || (st_r == ST_IND)
                            || (st_r == ST_OPER) || (st_r == ST_IO);
    wire [CYC_W-1:0]  endCyc = (st_r == ST_OPER && isMod) ? CYC_END_EXT : CYC_END; // RULE14
    wire              atHalf = cyc_r == CYC_HALF;
    wire              atEnd  = cyc_r == endCyc;
    wire dispatch = (st_r == ST_FETCH || st_r == ST_IND) && atEnd && !indFlag_r;
    wire execNow  = (st_r == ST_OPER && atEnd) || (dispatch && needOp && regOp);

    // Operand and adder
    wire [WORD_W-1:0] regVal = (ea_r == Y_ACC) ? acc_r : {{(WORD_W-ADDR_W){1'b0}}, pc_r};
    wire [WORD_W-1:0] opSrc  = (st_r == ST_OPER || st_r == ST_IO) ? opnd_r : regVal;
    wire [WORD_W-1:0] addX   = (fcode == OP_SUB) ? (~opSrc + WORD_ONE) : opSrc;
    wire [WORD_W-1:0] sum    = acc_r + addX; // RULE4
    wire [1:0] modeSel = (st_r == ST_IO)        ? MOD_DEC :
                         (fcode == OP_INCR)     ? MOD_INC :
                         (fcode == OP_IDXSKIP)  ? MOD_DEC : // RULE19
                         (fcode == OP_CSHIFT)   ? MOD_ROT8 : MOD_PASS;
    wire [WORD_W-1:0] status = {{(WORD_W-STAT_W){1'b0}}, lock_r, unit_r, mask_r}; // RULE22
    wire [WORD_W-1:0] wrData = (fcode == OP_STA)    ? acc_r :
                               (fcode == OP_STADR)  ? {opSrc[WORD_W-1:ADDR_W], acc_r[ADDR_W-1:0]} :
                               (fcode == OP_STSTAT) ? status :
                               isMod ? modOut : opSrc;
    wire blocked = (st_r == ST_OPER) && wrOp && protViol(opAddr, instrPc_r, mask_r); // RULE2

    // I/O priority, lowest channel first
    wire [IO_CH-1:0]   ioRise = ioS2_r & ~ioS3_r;
    wire [IO_CH_W-1:0] prio   = pend_r[0] ? 2'h0 : pend_r[1] ? 2'h1 : pend_r[2] ? 2'h2 : 2'h3;
    wire               ioTake = (st_r == ST_IO) && (cyc_r == '0);
    wire [IO_CH-1:0]   ioClr  = ioTake ? (IO_CH'(1) << prio) : '0;
    wire               runRise = runSync_r[1] & ~runSync_r[2];
    isc_state_t        nextSeq;
    assign nextSeq = (|pend_r) ? ST_IO : ST_FETCH; // RULE5

    wire [ADDR_W-1:0] seqAddr = (st_r == ST_FETCH) ? pc_r :
                                (st_r == ST_IO) ? (IO_BCW_BASE + {{(ADDR_W-IO_CH_W){1'b0}}, prio})
                                                : opAddr;
    wire [WORD_W-1:0] seqData = (st_r == ST_FETCH) ? instr_r :
                                (st_r == ST_IND)   ? opnd_r :
                                (st_r == ST_IO)    ? modOut : wrData;

    isc_incdec u_incdec (
        .wordIn  (opSrc),
        .mode    (modeSel),
        .wordOut (modOut)
    );

    // Sequence control
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= ST_HALT;
            cyc_r <= '0;
        end else begin
            cyc_r <= cyc_r + 6'h01;
            unique case (st_r)
                ST_HALT: begin
                    cyc_r <= '0;
                    if (runRise) st_r <= ST_FETCH;
                end
                ST_FETCH, ST_IND: if (atEnd) begin // RULE7 RULE16 RULE17
                    cyc_r <= '0;
                    if (indFlag_r) st_r <= ST_IND; // RULE11 RULE12
                    else if (needOp && !regOp) st_r <= ST_OPER; // RULE13
                    else if (fcode == OP_STOP) st_r <= ST_HALT;
                    else if (isShift && ea_r != '0) st_r <= ST_SHIFT; // RULE18
                    else st_r <= nextSeq; // RULE9 RULE24
                end
                ST_OPER, ST_IO: if (atEnd) begin
                    cyc_r <= '0;
                    st_r  <= nextSeq;
                end
                ST_SHIFT: if (cyc_r == STEP_END) begin
                    cyc_r <= '0;
                    if (shCnt_r == 15'h0001) st_r <= nextSeq;
                end
            endcase
        end
    end

    // Program counter and address path
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_r      <= RESET_PC;
            instrPc_r <= RESET_PC;
            instr_r   <= '0;
            opnd_r    <= '0;
            ea_r      <= '0;
            indFlag_r <= 1'b0;
        end else begin
            if (st_r == ST_FETCH && atHalf) begin // RULE8 RULE10
                instr_r   <= memRdData;
                instrPc_r <= pc_r;
                pc_r      <= pc_r + 16'h0001;
                ea_r      <= rdEa;
                indFlag_r <= memRdData[IND_BIT];
            end
            if (st_r == ST_IND && atHalf) begin // RULE12
                opnd_r    <= memRdData;
                ea_r      <= rdEa;
                indFlag_r <= memRdData[IND_BIT];
            end
            if ((st_r == ST_OPER || st_r == ST_IO) && atHalf) opnd_r <= memRdData;
            if (dispatch && fcode == OP_JUMP) pc_r <= opAddr;
            if (execNow && fcode == OP_IDXSKIP && modOut[WORD_W-1]) pc_r <= pc_r + 16'h0001; // RULE19
            if (execNow && wrOp && regOp && ea_r == Y_PC) pc_r <= wrData[ADDR_W-1:0]; // RULE23
        end
    end

    // Accumulator, index registers and designators
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r   <= '0;
            shCnt_r <= '0;
            mask_r  <= '0;
            unit_r  <= '0;
            lock_r  <= 1'b0;
            for (int i = 0; i < IDX_N; i++) idx_r[i] <= '0;
        end else begin
            if (dispatch && fcode == OP_LDCON) acc_r <= {{(WORD_W-Y_W){1'b0}}, ea_r};
            if (dispatch && isShift) shCnt_r <= ea_r;
            if (dispatch && fcode == OP_ESCAPE) unit_r <= ea_r[UNIT_W-1:0]; // RULE21
            if (dispatch && fcode == OP_MPROT) mask_r <= ea_r[MASK_W-1:0];
            if (dispatch && fcode == OP_LOCK) lock_r <= ea_r[0];
            if (st_r == ST_SHIFT && cyc_r == STEP_END) begin // RULE18
                shCnt_r <= shCnt_r - 15'h0001;
                acc_r   <= (fcode == OP_SHR) ? (acc_r >> 1) : (acc_r << 1);
            end
            if (execNow) begin
                if (fcode == OP_ADD || fcode == OP_SUB) acc_r <= sum; // RULE4
                if (fcode == OP_AND) acc_r <= acc_r & opSrc;
                if (fcode == OP_XOR) acc_r <= acc_r ^ opSrc;
                if (fcode == OP_LDA) acc_r <= opSrc;
                if (fcode == OP_LDB && curB != 2'h0) idx_r[curB - 2'h1] <= opSrc[IDX_W-1:0]; // RULE1
                if (fcode == OP_LDSTAT) begin // RULE22
                    mask_r <= opSrc[MASK_W-1:0];
                    unit_r <= opSrc[ST_UNIT_LO +: UNIT_W];
                    lock_r <= opSrc[ST_LOCK];
                end
                if (wrOp && regOp && ea_r == Y_ACC) acc_r <= wrData; // RULE13
            end
        end
    end

    // Memory strobes, protect and I/O service
    always_ff @(posedge clk) begin
        if (rst) begin
            mreq_r  <= '0;
            irq_r   <= 1'b0;
            grant_r <= 1'b0;
            done_r  <= 1'b0;
            chan_r  <= '0;
            pend_r  <= '0;
            halt_r  <= 1'b1;
        end else begin
            mreq_r.rd <= 1'b0;
            mreq_r.wr <= 1'b0;
            irq_r     <= 1'b0;
            grant_r   <= ioTake;
            done_r    <= 1'b0;
            halt_r    <= st_r == ST_HALT;
            pend_r    <= (pend_r & ~ioClr) | ioRise; // RULE5
            if (ioTake) chan_r <= prio;
            if (memSeq && cyc_r == '0) begin // RULE7
                mreq_r.rd   <= 1'b1;
                mreq_r.addr <= seqAddr;
            end
            if (memSeq && atEnd) begin
                if (blocked) irq_r <= 1'b1; // RULE3
                else begin
                    mreq_r.wr   <= 1'b1;
                    mreq_r.data <= seqData; // RULE6
                end
                if (st_r == ST_IO) done_r <= modOut == '0;
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk) begin
        runSync_r <= {runSync_r[1:0], runPin};
        ioS1_r    <= ioReqPin;
        ioS2_r    <= ioS1_r;
        ioS3_r    <= ioS2_r;
    end

    assign memReq     = mreq_r;
    assign ioGrant    = grant_r;
    assign ioChan     = chan_r;
    assign ioDone     = done_r;
    assign halted     = halt_r;
    assign protectIrq = irq_r;
    assign accOut     = acc_r;
    assign pcOut      = pc_r;
    assign unitSel    = unit_r;

    // Checks
    chk_rd_restore: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        mreq_r.rd |-> ##[36:41] (mreq_r.wr || irq_r))
        else $error("read not followed by restore");
    chk_fetch_pc: assert property ( // RULE8
        @(posedge clk) disable iff (rst)
        (st_r == ST_FETCH && atHalf) |=> (pc_r == $past(pc_r) + 16'h0001))
        else $error("fetch did not advance pc");
    chk_write_prot: assert property ( // RULE2
        @(posedge clk) disable iff (rst)
        (st_r == ST_OPER && atEnd && wrOp) |=>
            (mreq_r.wr != protViol(mreq_r.addr, instrPc_r, mask_r)))
        else $error("protect compare wrong");
    chk_prot_irq: assert property ( // RULE3
        @(posedge clk) disable iff (rst)
        irq_r |-> (!mreq_r.wr && $past(st_r) == ST_OPER))
        else $error("protect interrupt with write");
    chk_acc_add: assert property ( // RULE4
        @(posedge clk) disable iff (rst)
        (execNow && fcode == OP_ADD) |=> (acc_r == $past(acc_r) + $past(opSrc)))
        else $error("adder sum wrong");
    chk_io_noted: assert property ( // RULE5
        @(posedge clk) disable iff (rst)
        (ioRise != '0) |=> ((pend_r & $past(ioRise)) == $past(ioRise)))
        else $error("io request lost");
    chk_unit_hold: assert property ( // RULE21
        @(posedge clk) disable iff (rst)
        !(dispatch && fcode == OP_ESCAPE) && !(execNow && fcode == OP_LDSTAT)
            |=> $stable(unit_r))
        else $error("unit select changed");
    chk_mod_ext: assert property ( // RULE14
        @(posedge clk) disable iff (rst)
        (st_r == ST_OPER && isMod && mreq_r.rd) |-> ##41 (mreq_r.wr || irq_r))
        else $error("modify cycle not extended");
    chk_shift_step: assert property ( // RULE18
        @(posedge clk) disable iff (rst)
        (st_r == ST_SHIFT && cyc_r == STEP_END) |=> (shCnt_r == $past(shCnt_r) - 15'h0001))
        else $error("shift count step wrong");
    chk_reg_opnd: assert property ( // RULE13
        @(posedge clk) disable iff (rst)
        (dispatch && needOp && regOp) |=> (st_r != ST_OPER))
        else $error("operand sequence for register");

endmodule // isc_core

// ### test/isc_mem_model.sv
// Core memory model answering read and restore strobes
`timescale 1ns/1ps
module isc_mem_model
    import isc_pkg::*;
(
    // Clock and request
    input  wire logic              clk,
    input  wire isc_mreq_t         memReq,
    // Read latency, 1 to 16 cycles
    input  wire logic [4:0]        lat,
    // Read answer
    output logic      [WORD_W-1:0] memRdData
);
    logic [WORD_W-1:0] mem [0:65535];
    logic [4:0]        cnt = 5'h00;
    initial memRdData = 24'h000000;
    initial for (int i = 0; i < 65536; i++) mem[i] = 24'h000000;
    always @(posedge clk) begin
        if (memReq.rd) cnt <= lat;
        else if (cnt != 5'h00) cnt <= cnt - 5'h01;
        // Data line churns until the word is ready
        if (cnt == 5'h01) memRdData <= mem[memReq.addr];
        else if (memReq.rd || cnt > 5'h01) memRdData <= ~memRdData;
        if (memReq.wr) mem[memReq.addr] <= memReq.data;
    end
endmodule // isc_mem_model

// ### test/isc_testbench.sv
// Self-checking testbench of the instruction sequencer core
`timescale 1ns/1ps
module testbench;
    import isc_pkg::*;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               runPin = 1'b0;
    logic [IO_CH-1:0]   ioReqPin = 4'h0;
    logic [4:0]         lat = 5'h01;
    isc_mreq_t          memReq;
    logic [WORD_W-1:0]  memRdData;
    logic [WORD_W-1:0]  accOut;
    logic [ADDR_W-1:0]  pcOut;
    logic [IO_CH_W-1:0] ioChan;
    logic [UNIT_W-1:0]  unitSel;
    logic               ioGrant, ioDone, halted, protectIrq;
    int                 fails = 0, n_compared = 0, cycles = 0, nGrant, nDone, nIrq;
    int                 rdAt[$];
    always #10 clk = ~clk;
    isc_core i_dut (.clk(clk), .rst(rst), .runPin(runPin), .memReq(memReq),
        .memRdData(memRdData), .ioReqPin(ioReqPin), .ioGrant(ioGrant),
        .ioChan(ioChan), .ioDone(ioDone), .halted(halted), .protectIrq(protectIrq),
        .accOut(accOut), .pcOut(pcOut), .unitSel(unitSel));
    isc_mem_model i_mem (.clk(clk), .memReq(memReq), .lat(lat), .memRdData(memRdData));
    always @(posedge clk) begin
        cycles++;
        if (memReq.rd) rdAt.push_back(cycles);
        if (ioGrant) nGrant++;
        if (ioDone) nDone++;
        if (protectIrq) nIrq++;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end
    function automatic logic [WORD_W-1:0] ins(logic [5:0] f, logic i, logic [1:0] b,
                                             logic [14:0] y);
        return {f, i, b, y};
    endfunction
    task automatic cmp_word(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_count(string what, int exp, int got);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        runPin <= 1'b0;
        ioReqPin <= 4'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic run_to_halt();
        int n;
        rdAt.delete();
        nGrant = 0;
        nDone = 0;
        nIrq = 0;
        @(posedge clk) runPin <= 1'b1;
        for (n = 0; n < 20 && halted === 1'b1; n++) @(posedge clk);
        for (n = 0; n < 4000 && halted === 1'b0; n++) @(posedge clk);
        @(posedge clk) runPin <= 1'b0;
        cmp_word("halted", 24'h000001, {23'h0, halted});
    endtask
    task automatic test_reset();
        cmp_word("pc", {8'h00, RESET_PC}, {8'h00, pcOut});
        cmp_word("acc", 24'h000000, accOut);
        cmp_word("unit", 24'h000000, {21'h0, unitSel});
    endtask
    task automatic test_program();
        logic [WORD_W-1:0] p [12];
        p = '{ins(OP_LDCON, 1'b0, 2'h0, 15'h0005), ins(OP_ADD, 1'b0, 2'h0, 15'h0200),
              ins(OP_STA, 1'b0, 2'h0, 15'h0201), ins(OP_INCR, 1'b0, 2'h0, 15'h0202),
              ins(OP_CSHIFT, 1'b0, 2'h0, 15'h0203), ins(OP_ESCAPE, 1'b0, 2'h0, 15'h0003),
              ins(OP_LDB, 1'b0, 2'h1, 15'h0206), ins(OP_LDA, 1'b0, 2'h1, 15'h0204),
              ins(OP_MPROT, 1'b0, 2'h0, 15'h00FF), ins(OP_STA, 1'b0, 2'h0, 15'h0300),
              ins(6'h3F, 1'b0, 2'h0, 15'h0000), ins(OP_ADD, 1'b0, 2'h0, Y_ACC)};
        for (int a = 0; a < 12; a++) i_mem.mem[16'h0100 + a] = p[a];
        i_mem.mem[16'h010C] = ins(OP_STOP, 1'b0, 2'h0, 15'h0000);
        i_mem.mem[16'h0200] = 24'h000007;
        i_mem.mem[16'h0202] = 24'hFFFFFF;
        i_mem.mem[16'h0203] = 24'h123456;
        i_mem.mem[16'h0206] = 24'h000003;
        i_mem.mem[16'h0207] = 24'h00BEEF;
        i_mem.mem[16'h0042] = 24'h000001;
        ioReqPin <= 4'h4;
        run_to_halt();
        cmp_word("sum", 24'h00000C, i_mem.mem[16'h0201]);
        cmp_word("incr", 24'h000000, i_mem.mem[16'h0202]);
        cmp_word("rot", 24'h345612, i_mem.mem[16'h0203]);
        cmp_word("unit", 24'h000003, {21'h0, unitSel});
        cmp_word("acc", 24'h017DDE, accOut);
        cmp_word("guard", 24'h000000, i_mem.mem[16'h0300]);
        cmp_count("irq", 1, nIrq);
        cmp_word("count", 24'h000000, i_mem.mem[16'h0042]);
        cmp_count("grant", 1, nGrant);
        cmp_count("done", 1, nDone);
        cmp_word("chan", 24'h000002, {22'h0, ioChan});
        cmp_count("reads", 21, rdAt.size());
        cmp_word("pc", 24'h00010D, {8'h00, pcOut});
        cmp_word("restored", p[7], i_mem.mem[16'h0107]);
    endtask
    task automatic test_indirect();
        do_reset();
        lat <= 5'h10;
        i_mem.mem[16'h0100] = ins(OP_LDA, 1'b1, 2'h0, 15'h0210);
        i_mem.mem[16'h0101] = ins(OP_SHL, 1'b0, 2'h0, 15'h0004);
        i_mem.mem[16'h0102] = ins(OP_STOP, 1'b0, 2'h0, 15'h0000);
        i_mem.mem[16'h0210] = ins(6'h00, 1'b1, 2'h0, 15'h0211);
        i_mem.mem[16'h0211] = ins(6'h00, 1'b0, 2'h0, 15'h0212);
        i_mem.mem[16'h0212] = 24'hABCDEF;
        run_to_halt();
        cmp_word("shifted", 24'hBCDEF0, accOut);
        cmp_count("reads", 6, rdAt.size());
        cmp_count("ind1", MEM_CYCLES, rdAt[1] - rdAt[0]);
        cmp_count("ind2", MEM_CYCLES, rdAt[2] - rdAt[1]);
        cmp_count("shift", MEM_CYCLES + 4 * SHIFT_CYC, rdAt[5] - rdAt[4]);
    endtask
    task automatic test_misc();
        do_reset();
        i_mem.mem[16'h0100] = ins(OP_SUB, 1'b0, 2'h0, 15'h0180);
        i_mem.mem[16'h0101] = ins(OP_STA, 1'b0, 2'h0, 15'h0184);
        i_mem.mem[16'h0102] = ins(OP_IDXSKIP, 1'b0, 2'h0, 15'h0181);
        i_mem.mem[16'h0103] = ins(OP_STOP, 1'b0, 2'h0, 15'h0000);
        i_mem.mem[16'h0104] = ins(OP_LDSTAT, 1'b0, 2'h0, 15'h0182);
        i_mem.mem[16'h0105] = ins(OP_STSTAT, 1'b0, 2'h0, 15'h0183);
        i_mem.mem[16'h0106] = ins(OP_LDCON, 1'b0, 2'h0, 15'h1100);
        i_mem.mem[16'h0107] = ins(OP_SHR, 1'b0, 2'h0, 15'h0004);
        i_mem.mem[16'h0108] = ins(OP_STA, 1'b0, 2'h0, Y_PC);
        i_mem.mem[16'h0110] = ins(OP_JUMP, 1'b0, 2'h0, 15'h0112);
        i_mem.mem[16'h0111] = ins(OP_STOP, 1'b0, 2'h0, 15'h0000);
        i_mem.mem[16'h0112] = ins(OP_STOP, 1'b0, 2'h0, 15'h0000);
        i_mem.mem[16'h0180] = 24'h000005;
        i_mem.mem[16'h0181] = 24'h000000;
        i_mem.mem[16'h0182] = 24'h000E55;
        run_to_halt();
        cmp_word("sub", 24'hFFFFFB, i_mem.mem[16'h0184]);
        cmp_word("skipword", 24'hFFFFFF, i_mem.mem[16'h0181]);
        cmp_word("status", 24'h000E55, i_mem.mem[16'h0183]);
        cmp_word("unit", 24'h000006, {21'h0, unitSel});
        cmp_word("shr", 24'h000110, accOut);
        cmp_word("pc", 24'h000113, {8'h00, pcOut});
        cmp_count("reads", 15, rdAt.size());
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        do_reset();
        test_reset();
        test_program();
        test_indirect();
        test_misc();
        close_out();
    end
endmodule // testbench
